// ==== core/two_wire_defines.vh ====
// Register offsets, field positions, reset values and timing counts of the two-wire block.
`ifndef TWO_WIRE_DEFINES_VH
`define TWO_WIRE_DEFINES_VH
// Register byte offsets on the APB.
`define OFS_CTRL_ONE 12'h000
`define OFS_CTRL_TWO 12'h004
`define OFS_STATUS 12'h008
`define OFS_DATA_BUF 12'h00C
`define OFS_OWN_ADDR 12'h010
// Control register one fields.
`define C1_SCK_LSB 0
`define C1_MDD_BIT 3
`define C1_BC_LSB 4
`define C1_ACK_BIT 7
// Control register two fields.
`define C2_MODE_BIT 0
`define C2_SOFT_RESET_CODE_LSB 1
`define C2_PEND_BIT 4
`define C2_BUSY_BIT 5
`define C2_TRX_BIT 6
`define C2_MST_BIT 7
// Status register fields.
`define ST_LRB_BIT 0
`define ST_GC_BIT 1
`define ST_AAS_BIT 2
`define ST_AL_BIT 3
`define ST_PEND_BIT 4
`define ST_BUSY_BIT 5
`define ST_TRX_BIT 6
`define ST_MST_BIT 7
// Own address register fields.
`define OA_FREE_BIT 0
`define OA_SA_LSB 1
// Reset values.
`define RST_CTRL_ONE 8'h00
`define RST_OWN_ADDR 8'h00
// High period is 2^(sck+1)+7 clocks, low period three clocks longer.
`define THIGH_BASE 9'h007
`define TLOW_EXTRA 9'h003
`endif

// ==== core/bus_line_sync.v ====
// Synchroniser and edge, start and stop detector for the two bus lines.
`timescale 1ns/1ns
`default_nettype none
module bus_line_sync (
    // Clock and reset.
    input wire sys_clk,
    input wire srst,
    // Raw bus pins.
    input wire sclPin,
    input wire sdaPin,
    // Synchronised levels and one-cycle events.
    output reg sclBus,
    output reg sdaBus,
    output reg sclRise,
    output reg sclFall,
    output reg startDet,
    output reg stopDet
);
    // First stage flops; only the second stage reads them.
    reg sclMeta;
    reg sdaMeta;
    // Previous synchronised levels for edge finding.
    reg sclLast;
    reg sdaLast;

    // Two flops per line, then edges taken from the settled copies only.
    always @(posedge sys_clk) begin
        if (srst) begin
            sclMeta <= 1'b1;
            sdaMeta <= 1'b1;
            sclBus <= 1'b1;
            sdaBus <= 1'b1;
            sclLast <= 1'b1;
            sdaLast <= 1'b1;
            sclRise <= 1'b0;
            sclFall <= 1'b0;
            startDet <= 1'b0;
            stopDet <= 1'b0;
        end else begin
            sclMeta <= sclPin;
            sdaMeta <= sdaPin;
            sclBus <= sclMeta;
            sdaBus <= sdaMeta;
            sclLast <= sclBus;
            sdaLast <= sdaBus;
            sclRise <= sclBus & ~sclLast;
            sclFall <= ~sclBus & sclLast;
            // Data moving while the clock stays high marks start or stop.
            startDet <= sclBus & sclLast & sdaLast & ~sdaBus;
            stopDet <= sclBus & sclLast & ~sdaLast & sdaBus;
        end
    end
endmodule // bus_line_sync
`default_nettype wire

// ==== core/two_wire_bus_monitor.v ====
// Two-wire bus interface: arbitration, address monitors and start generation.
//
// Behaviour
// - Compare driven and bus data at clock rise
// - Arbitration loss drops master, transmit, clocking
// - Loser releases both data and clock
// - Loser clears pending and holds clock at word end
// - Data buffer access or control-two write clears loss
// - Slave own address or general call sets match
// - Detect disable keeps match and general call low outside free format
// - Free format: match after first word
// - Data buffer access clears address match
// - Eight zero bits after start set general call
// - Start or stop clears general call
// - Last received bit captured at clock rise
// - Free format treats everything as data
// - Start, high period, then address shifted out
// - Interrupt at word's last fall (ninth with eight bits and ack), pending cleared, clock held
// - Transmit select follows direction only on acknowledge
// - Buffer write sets pending; release after low time
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "two_wire_defines.vh"
module two_wire_bus_monitor (
    // Clock and reset.
    input wire sys_clk,
    input wire srst,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Bus pins, open drain; enables are low while pulling low.
    input wire sclPin,
    output reg sclOut,
    output reg sclOeN,
    input wire sdaPin,
    output reg sdaOut,
    output reg sdaOeN,
    // One-cycle interrupt request.
    output reg busInterruptRequest
);
    // Master clock engine states.
    localparam M_IDLE = 3'd0;
    localparam M_START = 3'd1;
    localparam M_LOW = 3'd2;
    localparam M_HIGH = 3'd3;
    localparam M_HOLD = 3'd4;

    // Synchronised bus view.
    wire sclBus;
    wire sdaBus;
    wire sclRise;
    wire sclFall;
    wire startDet;
    wire stopDet;

    // Software-visible state.
    reg [7:0] ctrlOne;
    reg busModeSelect;
    reg [1:0] softResetCode;
    reg masterSelect;
    reg transmitSelect;
    reg pending;
    reg busBusyFlag;
    reg arbitrationLostFlag;
    reg addressMatchFlag;
    reg generalCallFlag;
    reg lastReceivedBit;
    reg [7:0] ownAddress;
    reg [7:0] dataBuf;
    // Transfer tracking.
    reg [7:0] rxShift;
    reg [3:0] riseCnt;
    reg firstWord;
    reg slaveHold;
    reg [2:0] mState;
    reg [8:0] cnt;

    // Decoded control fields.
    wire [2:0] sckSel = ctrlOne[`C1_SCK_LSB +: 3];
    wire matchDetectDisable = ctrlOne[`C1_MDD_BIT];
    wire [2:0] wordBitCount = ctrlOne[`C1_BC_LSB +: 3];
    wire ackClock = ctrlOne[`C1_ACK_BIT];
    wire freeFormatSelect = ownAddress[`OA_FREE_BIT];
    wire [6:0] ownSlaveAddress = ownAddress[`OA_SA_LSB +: 7];
    wire [8:0] tHigh = `THIGH_BASE + (9'h002 << sckSel);
    wire [8:0] tLow = tHigh + `TLOW_EXTRA;
    // Bits per word; code zero means eight.
    wire [3:0] nBits = (wordBitCount == 3'h0) ? 4'h8 : {1'b0, wordBitCount};
    wire [3:0] nClocks = nBits + {3'h0, ackClock};
    wire ackSlot = ackClock && (riseCnt == nBits);
    wire wordEnd = sclFall && (riseCnt == nClocks);

    // APB decode; a transfer completes when pready is seen high.
    wire apbDone = psel & penable & pready;
    wire wrDone = apbDone & pwrite;
    wire rdDone = apbDone & ~pwrite;
    wire wrOne = wrDone && (paddr == `OFS_CTRL_ONE);
    wire wrTwo = wrDone && (paddr == `OFS_CTRL_TWO);
    wire wrData = wrDone && (paddr == `OFS_DATA_BUF);
    wire rdData = rdDone && (paddr == `OFS_DATA_BUF);
    wire wrOwn = wrDone && (paddr == `OFS_OWN_ADDR);
    wire mapped = (paddr == `OFS_CTRL_ONE) || (paddr == `OFS_CTRL_TWO) ||
        (paddr == `OFS_STATUS) || (paddr == `OFS_DATA_BUF) || (paddr == `OFS_OWN_ADDR);
    // Control two writes reach only the mode bit while the port mode is selected.
    wire wrTwoFull = wrTwo && busModeSelect;
    wire startCmd = wrTwoFull && !busBusyFlag && (pwdata[7:4] == 4'hF);
    // Slave address phase results.
    wire addrHit = (rxShift[7:1] == ownSlaveAddress) || (rxShift == 8'h00);
    wire addressed = addressMatchFlag | generalCallFlag;

    bus_line_sync u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .sclPin(sclPin),
        .sdaPin(sdaPin),
        .sclBus(sclBus),
        .sdaBus(sdaBus),
        .sclRise(sclRise),
        .sclFall(sclFall),
        .startDet(startDet),
        .stopDet(stopDet)
    );

    // Level this end wants on data for the current bit slot.
    reg sdaWant;
    always @* begin
        sdaWant = 1'b1;
        if (transmitSelect && (masterSelect || addressed) && (riseCnt < nBits)) begin
            sdaWant = dataBuf[3'd7 - riseCnt[2:0]];
        end else if (ackSlot && !transmitSelect && (masterSelect || addressed)) begin
            sdaWant = 1'b0;
        end else if (ackSlot && firstWord && !masterSelect && !freeFormatSelect &&
                     !matchDetectDisable && addrHit) begin
            // A slave acknowledges its own address or a general call.
            sdaWant = 1'b0;
        end
    end

    // APB answer: one wait state, read data registered with pready.
    always @(posedge sys_clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel & penable & ~pready) begin
                case (paddr)
                    `OFS_CTRL_ONE: prdata <= {24'h000000, ctrlOne};
                    `OFS_CTRL_TWO: prdata <= {24'h000000, masterSelect, transmitSelect,
                        busBusyFlag, pending, 1'b0, softResetCode, busModeSelect};
                    `OFS_STATUS: prdata <= {24'h000000, masterSelect, transmitSelect,
                        busBusyFlag, pending, arbitrationLostFlag, addressMatchFlag,
                        generalCallFlag, lastReceivedBit};
                    `OFS_DATA_BUF: prdata <= {24'h000000, dataBuf};
                    `OFS_OWN_ADDR: prdata <= {24'h000000, ownAddress};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration registers that only software changes.
    always @(posedge sys_clk) begin
        if (srst) begin
            ctrlOne <= `RST_CTRL_ONE;
            ownAddress <= `RST_OWN_ADDR;
            busModeSelect <= 1'b0;
            softResetCode <= 2'b00;
        end else begin
            if (wrOne) begin
                ctrlOne <= pwdata[7:0];
            end
            if (wrOwn) begin
                ownAddress <= pwdata[7:0];
            end
            if (wrTwo) begin
                busModeSelect <= pwdata[`C2_MODE_BIT];
            end
            if (wrTwoFull) begin
                softResetCode <= pwdata[`C2_SOFT_RESET_CODE_LSB +: 2];
            end
        end
    end

    // Bus watching: bit counting, receive shift, monitors and flags.
    always @(posedge sys_clk) begin
        if (srst) begin
            riseCnt <= 4'h0;
            rxShift <= 8'h00;
            firstWord <= 1'b0;
            busBusyFlag <= 1'b0;
            lastReceivedBit <= 1'b0;
            addressMatchFlag <= 1'b0;
            generalCallFlag <= 1'b0;
        end else begin
            if (sclRise) begin
                riseCnt <= riseCnt + 4'h1;
                lastReceivedBit <= sdaBus;
                if (riseCnt < nBits) begin
                    rxShift <= {rxShift[6:0], sdaBus};
                end
            end
            if (wordEnd) begin
                riseCnt <= 4'h0;
                firstWord <= 1'b0;
            end
            // Buffer access clears match; a new match below wins.
            if (wrData || rdData) begin
                addressMatchFlag <= 1'b0;
            end
            if (wordEnd && firstWord && !masterSelect) begin
                if (freeFormatSelect) begin
                    addressMatchFlag <= 1'b1;
                end else if (!matchDetectDisable) begin
                    // Own address or general call; gated by disable.
                    if (addrHit) begin
                        addressMatchFlag <= 1'b1;
                    end
                    if (rxShift == 8'h00) begin
                        generalCallFlag <= 1'b1;
                    end
                end
            end
            if (startDet) begin
                busBusyFlag <= 1'b1;
                riseCnt <= 4'h0;
                firstWord <= 1'b1;
                generalCallFlag <= 1'b0;
            end
            if (stopDet) begin
                busBusyFlag <= 1'b0;
                firstWord <= 1'b0;
                generalCallFlag <= 1'b0;
            end
        end
    end

    // Master engine, pending, arbitration and pin drive.
    always @(posedge sys_clk) begin
        if (srst) begin
            mState <= M_IDLE;
            cnt <= 9'h000;
            masterSelect <= 1'b0;
            transmitSelect <= 1'b0;
            pending <= 1'b0;
            arbitrationLostFlag <= 1'b0;
            slaveHold <= 1'b0;
            dataBuf <= 8'h00;
            busInterruptRequest <= 1'b0;
            sclOeN <= 1'b1;
            sdaOeN <= 1'b1;
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
        end else begin
            busInterruptRequest <= 1'b0;
            // Buffer access or control-two write clears the loss flag.
            if (wrData || rdData || wrTwo) begin
                arbitrationLostFlag <= 1'b0;
            end
            if (wrTwoFull) begin
                masterSelect <= pwdata[`C2_MST_BIT];
                transmitSelect <= pwdata[`C2_TRX_BIT];
            end
            if (wrData) begin
                dataBuf <= pwdata[7:0];
            end
            // Word end: receivers keep the word, then pending drops.
            if (wordEnd) begin
                if (!transmitSelect || arbitrationLostFlag) begin
                    dataBuf <= rxShift;
                end
                // Free format never reads a direction bit.
                if (!freeFormatSelect && firstWord) begin
                    if (masterSelect && !arbitrationLostFlag && !lastReceivedBit) begin
                        transmitSelect <= ~dataBuf[0];
                    end else if (!masterSelect && !matchDetectDisable && addrHit) begin
                        transmitSelect <= rxShift[0];
                    end
                end
                if (masterSelect || arbitrationLostFlag || addressed ||
                    (firstWord && !freeFormatSelect && !matchDetectDisable && addrHit)) begin
                    // Pending cleared, interrupt raised, clock held.
                    busInterruptRequest <= 1'b1;
                    pending <= 1'b0;
                    slaveHold <= ~masterSelect;
                end
            end
            if (stopDet) begin
                masterSelect <= 1'b0;
                transmitSelect <= 1'b0;
            end
            // Software can only set pending; its set wins.
            if (wrData || (wrTwoFull && pwdata[`C2_PEND_BIT])) begin
                pending <= 1'b1;
            end
            // Mismatch of driven and bus data at clock rise.
            // Only our own transmitted data bits are compared; the acknowledge slot
            // belongs to the receiver and would otherwise read as a false loss.
            if (sclRise && masterSelect && transmitSelect && (riseCnt < nBits) &&
                (sdaOeN != sdaBus) && !arbitrationLostFlag) begin
                arbitrationLostFlag <= 1'b1;
                // Drop to slave receiver and stop clocking.
                masterSelect <= 1'b0;
                transmitSelect <= 1'b0;
                mState <= M_IDLE;
                sclOeN <= 1'b1;
                sdaOeN <= 1'b1;
            end else begin
                // Data changes only while the bus clock is low, apart from the start.
                if (mState == M_START) begin
                    sdaOeN <= 1'b0;
                end else if (!sclBus) begin
                    sdaOeN <= sdaWant;
                end
                case (mState)
                    M_IDLE: begin
                        sclOeN <= ~slaveHold;
                        if (startCmd) begin
                            // Start: data low, then one high period.
                            mState <= M_START;
                            cnt <= tHigh;
                        end else if (slaveHold && pending) begin
                            // Slave release waits one low period.
                            if (cnt == 9'h000) begin
                                cnt <= tLow;
                            end else if (cnt == 9'h001) begin
                                slaveHold <= 1'b0;
                                cnt <= 9'h000;
                            end else begin
                                cnt <= cnt - 9'h001;
                            end
                        end else if (!slaveHold) begin
                            cnt <= 9'h000;
                        end
                    end
                    M_START: begin
                        if (cnt <= 9'h001) begin
                            sclOeN <= 1'b0;
                            cnt <= tLow;
                            mState <= M_LOW;
                        end else begin
                            cnt <= cnt - 9'h001;
                        end
                    end
                    M_LOW: begin
                        sclOeN <= 1'b0;
                        if (cnt <= 9'h001) begin
                            sclOeN <= 1'b1;
                            cnt <= tHigh;
                            mState <= M_HIGH;
                        end else begin
                            cnt <= cnt - 9'h001;
                        end
                    end
                    M_HIGH: begin
                        // High time counts only once the wired line is really high.
                        if (sclBus) begin
                            if (cnt <= 9'h001) begin
                                sclOeN <= 1'b0;
                                cnt <= tLow;
                                mState <= (riseCnt == nClocks) ? M_HOLD : M_LOW;
                            end else begin
                                cnt <= cnt - 9'h001;
                            end
                        end
                    end
                    M_HOLD: begin
                        // Clock held low while nothing is pending.
                        sclOeN <= 1'b0;
                        if (!masterSelect) begin
                            sclOeN <= 1'b1;
                            mState <= M_IDLE;
                        end else if (pending && !wordEnd && (riseCnt != nClocks)) begin
                            // Pending is still the old word's until the synced fall is seen.
                            cnt <= tLow;
                            mState <= M_LOW;
                        end
                    end
                    default: begin
                        mState <= M_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // two_wire_bus_monitor
`default_nettype wire

// ==== sim/two_wire_bus_monitor_sva.sv ====
// Checker of the bus monitor's APB answers and bus line timing.
`timescale 1ns/1ns
`default_nettype none
module two_wire_bus_monitor_sva (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic srst,
    // APB slave side.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Bus pins and interrupt.
    input wire logic sclPin,
    input wire logic sclOut,
    input wire logic sclOeN,
    input wire logic sdaPin,
    input wire logic sdaOut,
    input wire logic sdaOeN,
    input wire logic busInterruptRequest
);
    // Every check runs on the system clock and pauses in reset.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("APB answer not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("APB ready longer than one cycle");
    a_slverr_map: assert property (pready |-> pslverr == (paddr > 12'h010 || paddr[1:0] != 2'h0))
        else $error("Slave error does not match the address map");
    a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("Read data upper bits not zero");
    a_irq_pulse: assert property (busInterruptRequest |=> !busInterruptRequest)
        else $error("Interrupt request longer than one cycle");
    a_irq_hold: assert property (busInterruptRequest |=> ##1 !sclOeN [*4])
        else $error("Clock not held low after the interrupt");
    a_start_hold: assert property ($fell(sdaOeN) && sclPin && sclOeN |->
        sclOeN [*8] ##[1:300] !sclOeN)
        else $error("Start not followed by the high period and a clock fall");
    a_low_time: assert property ($fell(sclOeN) |=> !sclOeN [*8])
        else $error("Clock low period too short");
    // Open-drain pins only ever pull low; the enables do the work.
    a_drive_zero: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
        else $error("Open drain data not zero");
endmodule // two_wire_bus_monitor_sva
bind two_wire_bus_monitor two_wire_bus_monitor_sva chk (.sys_clk(sys_clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclPin(sclPin), .sclOut(sclOut),
    .sclOeN(sclOeN), .sdaPin(sdaPin), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .busInterruptRequest(busInterruptRequest));
`default_nettype wire

// ==== sim/bus_partner.sv ====
// Model of the other masters and slaves on the shared two-wire bus.
`timescale 1ns/1ns
`default_nettype none
module bus_partner (
    // Resolved bus lines.
    input wire logic scl,
    input wire logic sda,
    // Pulls, low drags the line down; released lines float to the pull-up.
    output logic sclPullN,
    output logic sdaPullN
);
    logic ackOn = 1'b0; // Act as an acknowledging slave.
    logic [8:0] got = 9'h000; // Line levels seen at clock rises.
    int n = 0; // Clock rises since the last start.
    initial begin
        sclPullN = 1'b1;
        sdaPullN = 1'b1;
    end
    // Count rises and record data; a start restarts the count.
    always @(posedge scl) begin
        got <= {got[7:0], sda};
        n <= n + 1;
    end
    always @(negedge sda) begin
        if (scl) begin
            n <= 0;
        end
    end
    // slave acknowledge slot: pull data low over the ninth clock.
    always @(negedge scl) begin
        if (ackOn) begin
            sdaPullN <= (n == 8) ? 1'b0 : 1'b1;
        end
    end
    // Clocks out bits MSB first at the link rate; leaves both lines low.
    task automatic send(input logic [8:0] s, input int nclk, input logic doStart);
        if (doStart) begin
            sdaPullN = 1'b0;
            #80;
        end
        for (int i = 0; i < nclk; i++) begin
            sclPullN = 1'b0;
            #40;
            sdaPullN = s[8 - i];
            #40;
            sclPullN = 1'b1;
            #80;
        end
        sclPullN = 1'b0;
        #40;
        sdaPullN = 1'b0;
    endtask
    // Stop: data rises while the clock is high, once any hold is let go.
    task automatic stop();
        sclPullN = 1'b1;
        wait (scl === 1'b1);
        #80;
        sdaPullN = 1'b1;
    endtask
endmodule // bus_partner
`default_nettype wire

// ==== sim/test_two_wire_bus_monitor.sv ====
// Self-checking bench for the two-wire bus monitor.
`timescale 1ns/1ns
`default_nettype none
`include "two_wire_defines.vh"
module test_two_wire_bus_monitor;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, sclOut, sclOeN, sdaOut, sdaOeN, irq;
    logic [8:0] st; // Last answer: slave error over read byte.
    wire logic sclLine, sdaLine, sclPullN, sdaPullN;
    int fails = 0, checks_done = 0, cyc = 0;
    // Slave cases: ctrl one, own address, byte sent, expected match flags.
    logic [31:0] cfg [6] = '{32'h80CACA04, 32'h80CA0006, 32'h88CACA00,
        32'h88CA0000, 32'h80CB0004, 32'h80CA2000};
    always #10 sys_clk = ~sys_clk;
    // Wired-AND lines with pull-ups.
    assign sclLine = sclOeN & sclPullN;
    assign sdaLine = sdaOeN & sdaPullN;
    bus_partner p (.scl(sclLine), .sda(sdaLine), .sclPullN(sclPullN), .sdaPullN(sdaPullN));
    two_wire_bus_monitor uut (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclPin(sclLine), .sclOut(sclOut), .sclOeN(sclOeN),
        .sdaPin(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .busInterruptRequest(irq));
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // A hung handshake counts as a mismatch.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; the request holds until ready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        st = {pslverr, prdata[7:0]};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitIrq();
        for (int t = 0; t < 3000 && irq !== 1'b1; t++) @(posedge sys_clk);
        chk("interrupt", {8'h00, irq}, 9'h001);
    endtask
    // reset, then set up as slave receiver.
    task automatic init(input logic [7:0] c1, input logic [7:0] oa);
        p.sclPullN = 1'b1;
        p.sdaPullN = 1'b1;
        srst <= 1'b1;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        apb(0, `OFS_CTRL_ONE, 8'h00);
        chk("ctrl one reset", st, {1'b0, `RST_CTRL_ONE});
        apb(0, `OFS_OWN_ADDR, 8'h00);
        chk("own address reset", st, {1'b0, `RST_OWN_ADDR});
        apb(1, `OFS_CTRL_TWO, 8'h01);
        apb(1, `OFS_CTRL_ONE, c1);
        apb(1, `OFS_OWN_ADDR, oa);
        apb(1, `OFS_CTRL_TWO, 8'h11);
    endtask
    initial begin
        // Master start with and without a slave acknowledge.
        for (int a = 0; a < 2; a++) begin
            init(8'h80, 8'h20);
            p.ackOn = a[0];
            // load address, then start at once.
            apb(1, `OFS_DATA_BUF, 8'hCB);
            apb(1, `OFS_CTRL_TWO, 8'hF1);
            waitIrq();
            chk("ninth fall", 9'(p.n), 9'h009);
            chk("sent byte", {1'b0, p.got[8:1]}, 9'h0CB);
            apb(0, `OFS_STATUS, 8'h00);
            chk("master status", st, a ? 9'h0A0 : 9'h0E1);
            repeat (40) @(posedge sys_clk);
            chk("clock held", {8'h00, sclLine}, 9'h000);
            apb(1, `OFS_DATA_BUF, 8'h00);
            apb(0, `OFS_STATUS, 8'h00);
            chk("pending set", {8'h00, st[4]}, 9'h001);
            $display("master start test %0d done", a);
        end
        // Another master holds data low from the start and wins.
        init(8'h80, 8'h20);
        p.ackOn = 1'b0;
        apb(1, `OFS_DATA_BUF, 8'hCB);
        apb(1, `OFS_CTRL_TWO, 8'hF1);
        @(negedge sdaLine);
        p.sdaPullN = 1'b0;
        repeat (60) @(posedge sys_clk);
        chk("loser released", {7'h00, sclOeN, sdaOeN}, 9'h003);
        apb(0, `OFS_STATUS, 8'h00);
        chk("loss status", st & 9'h0C8, 9'h008);
        p.send(9'h002, 8, 1'b0);
        waitIrq();
        apb(0, `OFS_STATUS, 8'h00);
        chk("loser word end", st, 9'h02E);
        apb(0, `OFS_DATA_BUF, 8'h00);
        apb(0, `OFS_STATUS, 8'h00);
        chk("after buffer read", st & 9'h00E, 9'h002);
        apb(1, `OFS_DATA_BUF, 8'h00);
        p.stop();
        repeat (20) @(posedge sys_clk);
        apb(0, `OFS_STATUS, 8'h00);
        chk("after stop", st & 9'h022, 9'h000);
        $display("arbitration test done");
        // Slave address, general call, disable and free format cases.
        for (int k = 0; k < 6; k++) begin
            init(cfg[k][31:24], cfg[k][23:16]);
            p.send({cfg[k][15:8], 1'b1}, 9, 1'b1);
            repeat (20) @(posedge sys_clk);
            apb(0, `OFS_STATUS, 8'h00);
            chk("slave flags", st & 9'h006, {1'b0, cfg[k][7:0]});
        end
        apb(0, 12'h014, 8'h00);
        chk("unmapped read", st, 9'h100);
        $display("slave and map tests done");
        results();
    end
endmodule // test_two_wire_bus_monitor
`default_nettype wire
